// file: audio_port_pkg.sv
`default_nettype none
package audio_port_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] PERIPHERAL_ID_OFFS        = 32'h01B4C000;
  localparam logic [31:0] PIN_FUNCTION_SELECT_OFFS  = 32'h01B4C010;
  localparam logic [31:0] PIN_DIRECTION_OFFS        = 32'h01B4C014;
  localparam logic [31:0] PIN_OUTPUT_VALUE_OFFS     = 32'h01B4C018;
  localparam logic [31:0] PIN_INPUT_OR_SET_OFFS     = 32'h01B4C01C;
  localparam logic [31:0] PIN_OUTPUT_CLEAR_OFFS     = 32'h01B4C020;
  localparam logic [31:0] GLOBAL_CONTROL_OFFS       = 32'h01B4C044;
  localparam logic [31:0] LOOPBACK_CONTROL_OFFS     = 32'h01B4C04C;
  localparam logic [31:0] RECEIVE_RESET_ALIAS_OFFS  = 32'h01B4C060;
  localparam logic [31:0] RECEIVE_BIT_MASK_OFFS     = 32'h01B4C064;
  localparam logic [31:0] RECEIVE_FORMAT_OFFS       = 32'h01B4C068;
  localparam logic [31:0] RECEIVE_SLOT_ENABLE_OFFS  = 32'h01B4C078;
  localparam logic [31:0] RECEIVE_STATUS_OFFS       = 32'h01B4C080;
  localparam logic [31:0] RECEIVE_CURRENT_SLOT_OFFS = 32'h01B4C084;
  localparam logic [31:0] TRANSMIT_RESET_ALIAS_OFFS = 32'h01B4C0A0;
  localparam logic [31:0] TRANSMIT_BIT_MASK_OFFS    = 32'h01B4C0A4;
  localparam logic [31:0] TRANSMIT_FORMAT_OFFS      = 32'h01B4C0A8;
  localparam logic [31:0] TRANSMIT_SLOT_ENABLE_OFFS = 32'h01B4C0B8;
  localparam logic [31:0] TRANSMIT_STATUS_OFFS      = 32'h01B4C0C0;
  localparam logic [31:0] TRANSMIT_CURRENT_SLOT_OFFS = 32'h01B4C0C4;
  localparam logic [31:0] IRQ_STATUS_OFFS           = 32'h01B4C0D0;
  localparam logic [31:0] IRQ_ENABLE_OFFS           = 32'h01B4C0D4;
  localparam logic [31:0] IRQ_CLEAR_OFFS            = 32'h01B4C0D8;
  localparam logic [31:0] TX_BUFFER_BASE_OFFS       = 32'h01B4C200;
  localparam logic [31:0] RX_BUFFER_BASE_OFFS       = 32'h01B4C280;
  // Plain storage registers; index 1 is the mute control
  localparam int unsigned PLAIN_COUNT = 13;
  localparam int unsigned MUTE_IDX    = 1;
  localparam logic [31:0] PLAIN_OFFS [PLAIN_COUNT] = '{
    32'h01B4C004, 32'h01B4C048, 32'h01B4C050, 32'h01B4C06C, 32'h01B4C070,
    32'h01B4C074, 32'h01B4C07C, 32'h01B4C088, 32'h01B4C0AC, 32'h01B4C0B0,
    32'h01B4C0B4, 32'h01B4C0BC, 32'h01B4C0C8};
  // ==========================================================
  // Field positions and masks
  localparam int unsigned GBL_RX_RUN_BIT   = 0;
  localparam int unsigned GBL_TX_RUN_BIT   = 8;
  localparam int unsigned GBL_SYNC_BIT     = 16;
  localparam logic [31:0] GBL_WRITE_MASK   = 32'h00010101;
  localparam logic [31:0] RX_ALIAS_MASK    = 32'h00000001;
  localparam logic [31:0] TX_ALIAS_MASK    = 32'h00000100;
  localparam int unsigned FMT_BURST_BIT    = 0;
  localparam int unsigned FMT_ENCODED_BIT  = 1;
  localparam int unsigned FMT_LAST_SLOT_LSB = 8;
  localparam logic [31:0] RX_FORMAT_WMASK  = 32'h00001F01;
  localparam logic [31:0] TX_FORMAT_WMASK  = 32'h00001F03;
  localparam int unsigned LOOPBACK_EN_BIT  = 0;
  localparam int unsigned MUTE_EN_BIT      = 0;
  localparam int unsigned IRQ_RX_WORD_BIT  = 0;
  localparam int unsigned IRQ_TX_REQ_BIT   = 1;
  localparam logic [31:0] CFG_RESET        = 32'h00000000;
  localparam logic [31:0] BIT_MASK_RESET   = 32'hFFFFFFFF;
  // ==========================================================
  // Per-direction configuration
  typedef struct packed {
    logic [31:0] bit_mask;
    logic [31:0] format;
    logic [31:0] slot_enable;
  } dir_cfg_s;
endpackage : audio_port_pkg
`default_nettype wire

// file: audio_serial_port.sv
`default_nettype none
// Contract
// - Transmit and receive run on their own bit clock and frame sync, or receive follows transmit.
// - Every serial data pin can be a transmit serializer, a receive serializer or GPIO.
// - Transmit sends plain TDM or biphase encoded audio, chosen by the transmit format.
// - Receive accepts TDM only; the encoded mode cannot be enabled for it.
// - All transmit serializers share one format and all receive serializers share another.
// - Both directions offer a burst mode in which each frame sync moves one single word.
// - Any pin not used for serial transfers works as a fully controlled GPIO.
// - The shared pin data word reads pin input levels and a write sets output bits.
// - The receive alias exposes only receiver reset bits of the global control.
// - The transmit alias exposes only transmitter reset bits of the global control.
// - Each direction has a slot enable mask picking which TDM slots take part.
// - Each direction reports its current TDM slot in a readable register.
// - A loop-back control routes transmit data into the receiver internally.
module audio_serial_port #(
  parameter int unsigned PINS      = 8,
  parameter int unsigned WORD_BITS = 32,
  parameter logic [31:0] PERIPHERAL_ID = 32'h00A5_0001  // Arbitrary identity value
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [31:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              write_i,
  input  wire logic              read_i,
  output var  logic [31:0]       rdata_o,
  input  wire logic              tx_bit_clk_i,
  input  wire logic              tx_frame_sync_i,
  input  wire logic              rx_bit_clk_i,
  input  wire logic              rx_frame_sync_i,
  input  wire logic [PINS-1:0]   serial_data_pin_i,
  output var  logic [PINS-1:0]   serial_data_pin_o,
  output var  logic [PINS-1:0]   serial_data_pin_oe_n_o,
  output var  logic              irq_o
);
  import audio_port_pkg::*;

  localparam int unsigned BIT_W = $clog2(WORD_BITS);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_BITS - 1);

  // ==========================================================
  // State
  logic [PINS+3:0]  meta, stable, stable_d;
  logic [PINS-1:0]  pin_function_select, pin_direction, pin_output_value;
  logic [31:0]      global_control, loopback_control, irq_enable;
  logic [31:0]      plain [PLAIN_COUNT];
  logic [31:0]      tx_buf [PINS];
  logic [31:0]      rx_buf [PINS];
  logic [WORD_BITS-1:0] rx_shift [PINS];
  dir_cfg_s         tx_cfg, rx_cfg;
  logic [1:0]       irq_status;
  logic [PINS-1:0]  tx_line, tx_bit_val, rx_din, is_tx, is_rx, pin_in;
  logic             tx_active, rx_active;
  logic [BIT_W-1:0] tx_bit, rx_bit;
  logic [4:0]       tx_slot, rx_slot, tx_last_slot, rx_last_slot;
  logic             tx_rise, tx_fall, tx_fs, rx_rise, rx_fs, use_tx_clk, loop_en;
  logic             tx_slot_on, rx_slot_on, tx_word_end, rx_word_end;
  logic             tx_req_evt, rx_word_evt, tx_run, rx_run, mute;
  logic [31:0]      rd_val;
  logic [1:0]       irq_clr;

  // ==========================================================
  // Link synchronisers; only stable and stable_d are looked at
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta     <= '0;
      stable   <= '0;
      stable_d <= '0;
    end
    else
    begin
      meta     <= {serial_data_pin_i, rx_frame_sync_i, rx_bit_clk_i,
                   tx_frame_sync_i, tx_bit_clk_i};
      stable   <= meta;
      stable_d <= stable;
    end
  end

  // Edge detection and clock source choice
  always_comb
  begin
    loop_en    = loopback_control[LOOPBACK_EN_BIT];
    use_tx_clk = global_control[GBL_SYNC_BIT] | loop_en;
    tx_run     = global_control[GBL_TX_RUN_BIT];
    rx_run     = global_control[GBL_RX_RUN_BIT];
    mute       = plain[MUTE_IDX][MUTE_EN_BIT];
    tx_rise    = stable[0] & ~stable_d[0];
    tx_fall    = ~stable[0] & stable_d[0];
    tx_fs      = stable[1];
    rx_rise    = use_tx_clk ? tx_rise : (stable[2] & ~stable_d[2]);
    rx_fs      = use_tx_clk ? stable[1] : stable[3];
    pin_in     = stable[PINS+3:4];
    is_tx      = ~pin_function_select & pin_direction;
    is_rx      = ~pin_function_select & ~pin_direction;
    // Burst mode makes every frame exactly one slot long
    tx_last_slot = tx_cfg.format[FMT_BURST_BIT] ? 5'h0
                   : tx_cfg.format[FMT_LAST_SLOT_LSB +: 5];
    rx_last_slot = rx_cfg.format[FMT_BURST_BIT] ? 5'h0
                   : rx_cfg.format[FMT_LAST_SLOT_LSB +: 5];
    tx_slot_on = tx_cfg.format[FMT_BURST_BIT] | tx_cfg.slot_enable[tx_slot];
    rx_slot_on = rx_cfg.format[FMT_BURST_BIT] | rx_cfg.slot_enable[rx_slot];
    tx_word_end = tx_run & tx_rise & ~tx_fs & tx_active & (tx_bit == LAST_BIT);
    rx_word_end = rx_run & rx_rise & ~rx_fs & rx_active & (rx_bit == LAST_BIT);
    tx_req_evt  = tx_word_end & tx_slot_on;
    rx_word_evt = rx_word_end & rx_slot_on;
    for (int i = 0; i < PINS; i++)
    begin
      // One shared transmit format for every serializer
      tx_bit_val[i] = tx_buf[i][LAST_BIT - tx_bit] & tx_cfg.bit_mask[LAST_BIT - tx_bit]
                      & tx_slot_on & ~mute;
      // Loop-back pairs each pin with its neighbour, so PINS must be even
      rx_din[i] = loop_en ? tx_line[i ^ 1] : pin_in[i];
    end
  end

  // ==========================================================
  // Transmit bit and slot counters; frame sync is taken on a rising edge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_active <= 1'b0;
      tx_bit    <= '0;
      tx_slot   <= 5'h0;
    end
    else if (!tx_run)
    begin
      tx_active <= 1'b0;
      tx_bit    <= '0;
      tx_slot   <= 5'h0;
    end
    else if (tx_rise)
    begin
      if (tx_fs)
      begin
        tx_active <= 1'b1;
        tx_bit    <= '0;
        tx_slot   <= 5'h0;
      end
      else if (tx_word_end)
      begin
        tx_bit <= '0;
        if (tx_slot == tx_last_slot)
          tx_active <= 1'b0;
        else
          tx_slot <= tx_slot + 5'h1;
      end
      else if (tx_active)
        tx_bit <= tx_bit + BIT_W'(1);
    end
  end

  // Plain TDM transmit lines change on the falling edge so the far end samples on the rising one
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_line <= '0;
    else if (!tx_run)
      tx_line <= '0;
    else if (tx_cfg.format[FMT_ENCODED_BIT])
    begin
      // Biphase mark: toggle on each bit boundary, again mid-bit for a one
      if (tx_rise & (tx_active | tx_fs))
        tx_line <= ~tx_line;
      else if (tx_fall & tx_active)
        tx_line <= tx_line ^ tx_bit_val;
    end
    else if (tx_fall)
      tx_line <= tx_active ? tx_bit_val : '0;
  end

  // ==========================================================
  // Receive counters and shifters; receive clocks may follow transmit
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_active <= 1'b0;
      rx_bit    <= '0;
      rx_slot   <= 5'h0;
    end
    else if (!rx_run)
    begin
      rx_active <= 1'b0;
      rx_bit    <= '0;
      rx_slot   <= 5'h0;
    end
    else if (rx_rise)
    begin
      if (rx_fs)
      begin
        rx_active <= 1'b1;
        rx_bit    <= '0;
        rx_slot   <= 5'h0;
      end
      else if (rx_word_end)
      begin
        rx_bit <= '0;
        if (rx_slot == rx_last_slot)
          rx_active <= 1'b0;
        else
          rx_slot <= rx_slot + 5'h1;
      end
      else if (rx_active)
        rx_bit <= rx_bit + BIT_W'(1);
    end
  end

  // Completed words land in the receive buffers through the shared mask
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        rx_shift[i] <= '0;
        rx_buf[i]   <= CFG_RESET;
      end
    end
    else if (rx_run & rx_rise & ~rx_fs & rx_active)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        rx_shift[i] <= {rx_shift[i][WORD_BITS-2:0], rx_din[i]};
        if (rx_word_evt & is_rx[i])
          rx_buf[i] <= 32'({rx_shift[i][WORD_BITS-2:0], rx_din[i]})
                       & rx_cfg.bit_mask;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_function_select <= '0;
      pin_direction       <= '0;
      global_control      <= CFG_RESET;
      loopback_control    <= CFG_RESET;
      irq_enable          <= CFG_RESET;
      tx_cfg              <= '{BIT_MASK_RESET, CFG_RESET, CFG_RESET};
      rx_cfg              <= '{BIT_MASK_RESET, CFG_RESET, CFG_RESET};
      for (int i = 0; i < PLAIN_COUNT; i++)
        plain[i] <= CFG_RESET;
      for (int i = 0; i < PINS; i++)
        tx_buf[i] <= CFG_RESET;
    end
    else if (write_i)
    begin
      unique case (addr_i)
        PIN_FUNCTION_SELECT_OFFS:  pin_function_select <= wdata_i[PINS-1:0];
        PIN_DIRECTION_OFFS:        pin_direction <= wdata_i[PINS-1:0];
        GLOBAL_CONTROL_OFFS:       global_control <= wdata_i & GBL_WRITE_MASK;
        RECEIVE_RESET_ALIAS_OFFS:
          global_control <= (global_control & ~RX_ALIAS_MASK)
                            | (wdata_i & RX_ALIAS_MASK);
        TRANSMIT_RESET_ALIAS_OFFS:
          global_control <= (global_control & ~TX_ALIAS_MASK)
                            | (wdata_i & TX_ALIAS_MASK);
        LOOPBACK_CONTROL_OFFS:     loopback_control <= wdata_i;
        IRQ_ENABLE_OFFS:           irq_enable <= wdata_i;
        RECEIVE_BIT_MASK_OFFS:     rx_cfg.bit_mask <= wdata_i;
        RECEIVE_FORMAT_OFFS:       rx_cfg.format <= wdata_i & RX_FORMAT_WMASK;
        RECEIVE_SLOT_ENABLE_OFFS:  rx_cfg.slot_enable <= wdata_i;
        TRANSMIT_BIT_MASK_OFFS:    tx_cfg.bit_mask <= wdata_i;
        TRANSMIT_FORMAT_OFFS:      tx_cfg.format <= wdata_i & TX_FORMAT_WMASK;
        TRANSMIT_SLOT_ENABLE_OFFS: tx_cfg.slot_enable <= wdata_i;
        default:
        begin
          for (int i = 0; i < PLAIN_COUNT; i++)
            if (addr_i == PLAIN_OFFS[i])
              plain[i] <= wdata_i;
          for (int i = 0; i < PINS; i++)
            if (addr_i == TX_BUFFER_BASE_OFFS + 32'(4 * i))
              tx_buf[i] <= wdata_i;
        end
      endcase
    end
  end

  // GPIO output value; set and clear words touch only the selected bits
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_output_value <= '0;
    else if (write_i && addr_i == PIN_OUTPUT_VALUE_OFFS)
      pin_output_value <= wdata_i[PINS-1:0];
    else if (write_i && addr_i == PIN_INPUT_OR_SET_OFFS)
      pin_output_value <= pin_output_value | wdata_i[PINS-1:0];
    else if (write_i && addr_i == PIN_OUTPUT_CLEAR_OFFS)
      pin_output_value <= pin_output_value & ~wdata_i[PINS-1:0];
  end

  // Sticky events; a new event beats a clear in the same cycle
  assign irq_clr = (write_i && addr_i == IRQ_CLEAR_OFFS) ? wdata_i[1:0] : 2'h0;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_status <= 2'h0;
      irq_o      <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | {tx_req_evt, rx_word_evt};
      irq_o      <= |(irq_status & irq_enable[1:0]);
    end
  end

  // ==========================================================
  // Read decode; unmapped addresses read as zero
  always_comb
  begin
    rd_val = 32'h0;
    unique case (addr_i)
      PERIPHERAL_ID_OFFS:        rd_val = PERIPHERAL_ID;
      PIN_FUNCTION_SELECT_OFFS:  rd_val = 32'(pin_function_select);
      PIN_DIRECTION_OFFS:        rd_val = 32'(pin_direction);
      PIN_OUTPUT_VALUE_OFFS:     rd_val = 32'(pin_output_value);
      PIN_INPUT_OR_SET_OFFS:     rd_val = 32'(pin_in);
      GLOBAL_CONTROL_OFFS:       rd_val = global_control;
      RECEIVE_RESET_ALIAS_OFFS:  rd_val = global_control & RX_ALIAS_MASK;
      TRANSMIT_RESET_ALIAS_OFFS: rd_val = global_control & TX_ALIAS_MASK;
      LOOPBACK_CONTROL_OFFS:     rd_val = loopback_control;
      IRQ_STATUS_OFFS:           rd_val = 32'(irq_status);
      IRQ_ENABLE_OFFS:           rd_val = irq_enable;
      RECEIVE_BIT_MASK_OFFS:     rd_val = rx_cfg.bit_mask;
      RECEIVE_FORMAT_OFFS:       rd_val = rx_cfg.format;
      RECEIVE_SLOT_ENABLE_OFFS:  rd_val = rx_cfg.slot_enable;
      RECEIVE_STATUS_OFFS:       rd_val = {30'h0, rx_active, irq_status[IRQ_RX_WORD_BIT]};
      RECEIVE_CURRENT_SLOT_OFFS: rd_val = 32'(rx_slot);
      TRANSMIT_BIT_MASK_OFFS:    rd_val = tx_cfg.bit_mask;
      TRANSMIT_FORMAT_OFFS:      rd_val = tx_cfg.format;
      TRANSMIT_SLOT_ENABLE_OFFS: rd_val = tx_cfg.slot_enable;
      TRANSMIT_STATUS_OFFS:      rd_val = {30'h0, tx_active, irq_status[IRQ_TX_REQ_BIT]};
      TRANSMIT_CURRENT_SLOT_OFFS: rd_val = 32'(tx_slot);
      default:
      begin
        for (int i = 0; i < PLAIN_COUNT; i++)
          if (addr_i == PLAIN_OFFS[i])
            rd_val = plain[i];
        for (int i = 0; i < PINS; i++)
        begin
          if (addr_i == TX_BUFFER_BASE_OFFS + 32'(4 * i))
            rd_val = tx_buf[i];
          if (addr_i == RX_BUFFER_BASE_OFFS + 32'(4 * i))
            rd_val = rx_buf[i];
        end
      end
    endcase
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 32'h0;
    else
      rdata_o <= read_i ? rd_val : 32'h0;
  end

  // Pin drivers: GPIO, transmit serializer or receive (released)
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      serial_data_pin_o      <= '0;
      serial_data_pin_oe_n_o <= '1;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        if (pin_function_select[i])
        begin
          serial_data_pin_o[i]      <= pin_output_value[i];
          serial_data_pin_oe_n_o[i] <= ~pin_direction[i];
        end
        else
        begin
          serial_data_pin_o[i]      <= is_tx[i] & tx_line[i];
          serial_data_pin_oe_n_o[i] <= ~(is_tx[i] & tx_run);
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  set_bits_a: assert property (write_i && addr_i == PIN_INPUT_OR_SET_OFFS |=>
    (pin_output_value & $past(wdata_i[PINS-1:0])) == $past(wdata_i[PINS-1:0]))
    else $error("set word did not raise output bits");
  input_read_a: assert property (read_i && addr_i == PIN_INPUT_OR_SET_OFFS |=>
    rdata_o == 32'($past(pin_in)))
    else $error("pin input levels not returned");
  rx_alias_only_a: assert property (write_i && addr_i == RECEIVE_RESET_ALIAS_OFFS |=>
    global_control[GBL_TX_RUN_BIT] == $past(global_control[GBL_TX_RUN_BIT]))
    else $error("receive alias touched transmitter");
  tx_alias_only_a: assert property (write_i && addr_i == TRANSMIT_RESET_ALIAS_OFFS |=>
    global_control[GBL_RX_RUN_BIT] == $past(global_control[GBL_RX_RUN_BIT]))
    else $error("transmit alias touched receiver");
  rx_no_encode_a: assert property (!rx_cfg.format[FMT_ENCODED_BIT])
    else $error("receive encoded mode enabled");
  slot_mask_a: assert property (tx_run && !tx_cfg.format[FMT_ENCODED_BIT] && tx_fall
    && !tx_slot_on |=> tx_line == '0)
    else $error("disabled slot drove data");
  slot_report_a: assert property (read_i && addr_i == TRANSMIT_CURRENT_SLOT_OFFS |=>
    rdata_o == 32'($past(tx_slot)))
    else $error("current slot mismatch");
  gpio_drive_a: assert property (pin_function_select[0] && pin_direction[0] |=>
    !serial_data_pin_oe_n_o[0] && serial_data_pin_o[0] == $past(pin_output_value[0]))
    else $error("gpio output not driven");
  burst_slot_a: assert property (tx_cfg.format[FMT_BURST_BIT] |-> tx_slot == 5'h0)
    else $error("burst frame passed slot zero");
  irq_raise_a: assert property (rx_word_evt && irq_enable[0]
    ##1 !(write_i && addr_i == IRQ_CLEAR_OFFS) |=> irq_o)
    else $error("interrupt not raised");
  read_idle_a: assert property (!$past(read_i) |-> rdata_o == 32'h0)
    else $error("read data outside answer cycle");

  tx_word_c:   cover property (tx_req_evt);
  rx_word_c:   cover property (rx_word_evt);
  loop_word_c: cover property (loop_en && rx_word_evt);
  encoded_c:   cover property (tx_cfg.format[FMT_ENCODED_BIT] && tx_req_evt);
endmodule : audio_serial_port
`default_nettype wire

// file: audio_codec_model.sv
`default_nettype none
// ==========================================
// Far-side codec: makes the link clocks, talks on one line, listens on another
module audio_codec_model (
  input  wire logic        line_i,
  output var  logic        bit_clk_o,
  output var  logic        frame_sync_o,
  output var  logic        line_o,
  output var  logic [31:0] heard_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link clock stands still low between frames
  initial
  begin
    bit_clk_o    = 1'b0;
    frame_sync_o = 1'b0;
    line_o       = 1'b0;
    heard_o      = 32'h0;
  end
  // One single-slot frame, 200 ns bit period, most significant bit first
  task automatic frame(input logic [31:0] say);
    // Start off the system clock edge so no pin change races its sampling
    #5 frame_sync_o = 1'b1;
    #100 bit_clk_o = 1'b1;
    #100 bit_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      line_o = say[i];
      #100 bit_clk_o = 1'b1;
      // Listen late in the bit: the port's output lags its synchronizers
      #90 heard_o[i] = line_i;
      #10 bit_clk_o = 1'b0;
    end
    // Line released without a pull: show the inverse, not the last bit
    line_o = ~line_o;
  endtask : frame
endmodule : audio_codec_model
`default_nettype wire

// file: test_audio_serial_port.sv
`default_nettype none
module test_audio_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  import audio_port_pkg::*;
  localparam logic [31:0] ID = 32'h00A5_0001;  // Arbitrary identity value
  logic clk_i = 1'b0, arst_n_i = 1'b0, write_i = 1'b0, read_i = 1'b0;
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o;
  logic [7:0]  pin_o, oe_n, wire_lvl;
  logic        irq_o, bclk, fs, talk;
  logic [31:0] heard;
  int          failures = 0, num_checks = 0;
  // ==========================================
  // Pin wires: the port wins where it drives, else the outside levels
  assign wire_lvl = (~oe_n & pin_o) | (oe_n & {4'hA, 2'b00, talk, 1'b1});
  audio_serial_port #(.PERIPHERAL_ID(ID)) i_audio_serial_port (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .tx_bit_clk_i(bclk), .tx_frame_sync_i(fs), .rx_bit_clk_i(bclk),
    .rx_frame_sync_i(fs), .serial_data_pin_i(wire_lvl), .serial_data_pin_o(pin_o),
    .serial_data_pin_oe_n_o(oe_n), .irq_o(irq_o));
  audio_codec_model i_audio_codec_model (
    .line_i(wire_lvl[0]), .bit_clk_o(bclk), .frame_sync_o(fs), .line_o(talk),
    .heard_o(heard));
  always #12.5 clk_i = ~clk_i;
  // ==========================================
  // Bus tasks; strobes drop at the next edge, so calls never share an edge
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask : wr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata_o);
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Watchdog: the tests need well under 100 us
  initial
  begin
    #500us;
    failures++;
    report_and_stop();
  end
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wr(PERIPHERAL_ID_OFFS, 32'h0);
    rd(PERIPHERAL_ID_OFFS, ID);
    rd(TRANSMIT_BIT_MASK_OFFS, BIT_MASK_RESET);
    rd(GLOBAL_CONTROL_OFFS, 32'h0);
    rd(32'h01B4C008, 32'h0);
    $display("test reset values done");
    wr(PIN_FUNCTION_SELECT_OFFS, 32'h000000FF);
    wr(PIN_DIRECTION_OFFS, 32'h0000000F);
    wr(PIN_OUTPUT_VALUE_OFFS, 32'h00000005);
    wr(PIN_INPUT_OR_SET_OFFS, 32'h0000000A);
    rd(PIN_OUTPUT_VALUE_OFFS, 32'h0000000F);
    wr(PIN_OUTPUT_CLEAR_OFFS, 32'h00000003);
    rd(PIN_OUTPUT_VALUE_OFFS, 32'h0000000C);
    repeat (4) @(posedge clk_i);
    rd(PIN_INPUT_OR_SET_OFFS, 32'h000000AC);
    chk("pin drive", 32'h000000F0, {24'h0, oe_n});
    $display("test gpio done");
    wr(RECEIVE_RESET_ALIAS_OFFS, 32'hFFFFFFFF);
    rd(GLOBAL_CONTROL_OFFS, RX_ALIAS_MASK);
    rd(TRANSMIT_RESET_ALIAS_OFFS, 32'h0);
    wr(TRANSMIT_RESET_ALIAS_OFFS, 32'hFFFFFFFF);
    rd(GLOBAL_CONTROL_OFFS, 32'h00000101);
    rd(RECEIVE_RESET_ALIAS_OFFS, RX_ALIAS_MASK);
    wr(GLOBAL_CONTROL_OFFS, 32'h0);
    wr(RECEIVE_FORMAT_OFFS, 32'hFFFFFFFF);
    rd(RECEIVE_FORMAT_OFFS, RX_FORMAT_WMASK);
    wr(RECEIVE_FORMAT_OFFS, 32'h0);
    $display("test aliases done");
    // Pin 0 transmits, pin 1 receives, receive follows the transmit clocks
    wr(PIN_FUNCTION_SELECT_OFFS, 32'h0);
    wr(PIN_DIRECTION_OFFS, 32'h00000001);
    wr(TX_BUFFER_BASE_OFFS, 32'hC3A50F96);
    wr(TRANSMIT_SLOT_ENABLE_OFFS, 32'h00000001);
    wr(RECEIVE_SLOT_ENABLE_OFFS, 32'h00000001);
    wr(IRQ_ENABLE_OFFS, 32'h00000003);
    wr(GLOBAL_CONTROL_OFFS, 32'h00010101);
    i_audio_codec_model.frame(32'h5A3C81E7);
    repeat (8) @(posedge clk_i);
    chk("tx word", 32'hC3A50F96, heard);
    rd(RX_BUFFER_BASE_OFFS + 32'h4, 32'h5A3C81E7);
    chk("irq set", 32'h1, {31'h0, irq_o});
    rd(IRQ_STATUS_OFFS, 32'h00000003);
    wr(IRQ_CLEAR_OFFS, 32'h00000003);
    repeat (2) @(posedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    $display("test frame done");
    wr(TRANSMIT_SLOT_ENABLE_OFFS, 32'h0);
    i_audio_codec_model.frame(32'h0F0F0F0F);
    repeat (8) @(posedge clk_i);
    chk("masked slot", 32'h0, heard);
    $display("test slot mask done");
    // Loop-back without the sync bit; burst ignores the cleared slot mask
    wr(GLOBAL_CONTROL_OFFS, 32'h00000101);
    wr(LOOPBACK_CONTROL_OFFS, 32'h00000001);
    wr(TRANSMIT_FORMAT_OFFS, 32'h00000001);
    wr(RECEIVE_FORMAT_OFFS, 32'h00000001);
    i_audio_codec_model.frame(32'h00000000);
    repeat (8) @(posedge clk_i);
    chk("burst word", 32'hC3A50F96, heard);
    rd(RX_BUFFER_BASE_OFFS + 32'h4, 32'hC3A50F96);
    $display("test loopback burst done");
    report_and_stop();
  end
endmodule : test_audio_serial_port
`default_nettype wire
